/* sim/port_priority_tag_control_tb_top.sv */
/*
 Self-checking bench for the per-port priority and tag control bank.
 Assumes the design package and a 40 MHz clock; bench drives every port itself.
*/
`timescale 1ns/100ps
module port_priority_tag_control_tb_top;
    import port_prio_tag_pkg::*;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [ADDR_W-1:0] reg_addr_i = '0;
    logic [DATA_W-1:0] reg_wdata_i = '0, reg_rdata_o;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, class_req_i = 1'b0, egr_req_i = 1'b0;
    logic [PORT_W-1:0] class_port_i = '0, egr_port_i = '0;
    logic dscp_hit_i = 1'b0, dot1p_hit_i = 1'b0, arrived_tagged_i = 1'b0;
    logic [PRIO_W-1:0] dscp_prio_i = '0, dot1p_prio_i = '0, egr_prio_i = '0, class_prio_o, egr_queue_o;
    logic [VID_W-1:0] port_default_vlan_id_i = '0, tag_vid_o;
    logic class_valid_o, egr_valid_o, insert_tag_o, strip_tag_o;
    logic [NUM_PORTS-1:0] storm_protect_o;
    logic [31:0] lfsr = 32'hBA6F;
    logic [7:0] m_ctrl [0:7];
    logic m_split [0:7];
    int bad_count = 0;
    int compares = 0;

    // Clock, 25 ns period
    always #12.5 clock_i = ~clock_i;

    port_prio_tag_ctrl DUT (.clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .class_req_i(class_req_i), .class_port_i(class_port_i), .dscp_hit_i(dscp_hit_i),
        .dscp_prio_i(dscp_prio_i), .dot1p_hit_i(dot1p_hit_i), .dot1p_prio_i(dot1p_prio_i),
        .class_valid_o(class_valid_o), .class_prio_o(class_prio_o), .egr_req_i(egr_req_i),
        .egr_port_i(egr_port_i), .egr_prio_i(egr_prio_i), .arrived_tagged_i(arrived_tagged_i),
        .port_default_vlan_id_i(port_default_vlan_id_i), .egr_valid_o(egr_valid_o),
        .egr_queue_o(egr_queue_o), .insert_tag_o(insert_tag_o), .strip_tag_o(strip_tag_o),
        .tag_vid_o(tag_vid_o), .storm_protect_o(storm_protect_o));

    // Random source, fixed start
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Reset held 3 cycles, model cleared, first request after 3 more edges
    task automatic do_reset();
        // Mid-run, assert on a rising edge like every other input
        if (resetn_i) begin
            @(posedge clock_i);
        end
        resetn_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            m_ctrl[i] = 8'h00;
            m_split[i] = 1'b0;
        end
        repeat (3) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
    endtask

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1;
        check({4'h0, reg_rdata_o}, {4'h0, exp});
    endtask

    // Write then read the same address back to back, no idle cycle
    task automatic reg_write_read(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1;
        check({4'h0, reg_rdata_o}, {4'h0, exp});
    endtask

    // Every mapped register and the storm outputs against the model
    task automatic check_regs();
        logic [NUM_PORTS-1:0] st;
        for (int p = 1; p <= 5; p++) begin
            reg_read(ADDR_W'(p * 64), m_ctrl[p]);
            reg_read(ADDR_W'(10'h2C4 + (p - 1) * 64), {6'h00, m_split[p], 1'b0});
            st[p-1] = m_ctrl[p][7];
        end
        check({7'h00, storm_protect_o}, {7'h00, st});
    endtask

    // One classification plus one egress decision, compared with the model
    task automatic decide(input logic [31:0] r, input logic [31:0] s);
        logic [7:0] c, e;
        logic [1:0] q, pr, code;
        logic ins;
        c = m_ctrl[r[2:0]];
        e = m_ctrl[s[2:0]];
        if (c[6] && r[3] && c[5] && r[6]) pr = r[5:4] | r[8:7];
        else if (c[6] && r[3]) pr = r[5:4];
        else if (c[5] && r[6]) pr = r[8:7];
        else pr = c[4:3];
        code = {m_split[s[2:0]], e[0]};
        q = (code == 2'b10) ? s[4:3] : (code == 2'b01) ? {1'b0, s[4]} : 2'h0;
        ins = e[2] && !s[5];
        @(posedge clock_i);
        class_req_i <= 1'b1;
        {dot1p_prio_i, dot1p_hit_i, dscp_prio_i, dscp_hit_i, class_port_i} <= r[8:0];
        egr_req_i <= 1'b1;
        {arrived_tagged_i, egr_prio_i, egr_port_i} <= s[5:0];
        port_default_vlan_id_i <= s[17:6];
        @(posedge clock_i);
        class_req_i <= 1'b0;
        egr_req_i <= 1'b0;
        #1;
        check({11'h000, class_valid_o}, 12'h001);
        check({10'h000, class_prio_o}, {10'h000, pr});
        check({11'h000, egr_valid_o}, 12'h001);
        check({10'h000, egr_queue_o}, {10'h000, q});
        check({10'h000, insert_tag_o, strip_tag_o}, {10'h000, ins, e[1] && s[5]});
        check(tag_vid_o, ins ? s[17:6] : 12'h000);
    endtask

    // Watchdog, well beyond the expected run length
    initial begin
        #(25 * 40000);
        bad_count++;
        end_of_test();
    end

    initial begin
        logic [31:0] r;
        do_reset();
        check_regs();
        decide(32'h0000_000A, 32'h0002_0021);
        $display("Test reset defaults done");
        // Bad addresses: unaligned and unmapped are ignored
        reg_write(10'h041, 8'hFF);
        reg_write(10'h044, 8'hFF);
        reg_write(10'h180, 8'hFF);
        reg_read(10'h044, 8'h00);
        reg_read(10'h041, 8'h00);
        reg_read(10'h2C5, 8'h00);
        check_regs();
        $display("Test refused addresses done");
        // Every field value, all split codes, random traffic
        for (int i = 0; i < 300; i++) begin
            if (i % 6 == 0) begin
                r = rnd();
                r[2:0] = 3'(1 + (r[2:0] % 5));
                m_ctrl[r[2:0]] = r[15:8];
                m_split[r[2:0]] = r[17];
                reg_write_read(ADDR_W'(r[2:0] * 64), r[15:8], m_ctrl[r[2:0]]);
                reg_write_read(ADDR_W'(10'h2C4 + (r[2:0] - 1) * 64), r[23:16],
                    {6'h00, m_split[r[2:0]], 1'b0});
            end
            decide(rnd(), rnd());
        end
        check_regs();
        $display("Test random programming done");
        // Second reset mid-run clears everything
        do_reset();
        check_regs();
        decide(rnd(), rnd());
        $display("Test second reset done");
        end_of_test();
    end
endmodule

/* src/port_prio_tag_ctrl.sv */
/*
 Per-port priority classification and egress tag control register bank.
 Fabric requests come from logic on clock_i; register port is synchronous.
*/
// The address-and-strobe port was left to the implementer.
// Contract
// - Control bit 6 enables DiffServ priority classification on ingress.
// - Control bit 5 enables 802.1p priority classification on ingress.
// - Bits 4-3 give default queue when no classifier enabled or hits.
// - Both classifiers may be on; their results are ORed, overriding default.
// - Bit 2 adds tag with ingress port default VLAN to untagged frames.
// - Insertion never adds a second tag to already tagged frames.
// - Bit 1 strips tag from frames that arrived tagged.
// - Removal leaves frames that arrived untagged unaltered.
// - Split code is companion bit 1 over control bit 0; 11 reserved.
// - Single queue setting sends everything through queue zero.
// - Both registers repeat per port 1 to 5 at own addresses.
// - Control bit 7 enables broadcast storm protection for the port.
`timescale 1ns/100ps
module port_prio_tag_ctrl
    import port_prio_tag_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    // Ingress classification request
    input wire logic class_req_i,
    input wire logic [PORT_W-1:0] class_port_i,
    input wire logic dscp_hit_i,
    input wire logic [PRIO_W-1:0] dscp_prio_i,
    input wire logic dot1p_hit_i,
    input wire logic [PRIO_W-1:0] dot1p_prio_i,
    output logic class_valid_o,
    output logic [PRIO_W-1:0] class_prio_o,
    // Egress request
    input wire logic egr_req_i,
    input wire logic [PORT_W-1:0] egr_port_i,
    input wire logic [PRIO_W-1:0] egr_prio_i,
    input wire logic arrived_tagged_i,
    input wire logic [VID_W-1:0] port_default_vlan_id_i,
    output logic egr_valid_o,
    output logic [PRIO_W-1:0] egr_queue_o,
    output logic insert_tag_o,
    output logic strip_tag_o,
    output logic [VID_W-1:0] tag_vid_o,
    // Per-port storm protection enables, bit 0 is port 1
    output logic [NUM_PORTS-1:0] storm_protect_o
);

    // Port number to slot; valid flag on top
    function automatic logic [PORT_W:0] port_slot(input logic [PORT_W-1:0] p);
        logic ok;
        ok = (p >= PORT_FIRST) && (p <= PORT_LAST);
        return {ok, ok ? PORT_W'(p - PORT_FIRST) : {PORT_W{1'b0}}};
    endfunction

    // Byte address to {hit, companion, slot}
    function automatic logic [PORT_W+1:0] decode(input logic [ADDR_W-1:0] a);
        logic [IDX_W-1:0] idx;
        logic [PORT_W+1:0] res;
        idx = a[ADDR_W-1:2];
        res = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (a[1:0] == LANE_ZERO) begin
                if (idx == IDX_W'(CTRL_IDX_FIRST + CTRL_IDX_STEP * IDX_W'(p))) begin
                    res = {1'b1, 1'b0, PORT_W'(p)};
                end
                if (idx == IDX_W'(SPLIT_IDX_FIRST + SPLIT_IDX_STEP * IDX_W'(p))) begin
                    res = {1'b1, 1'b1, PORT_W'(p)};
                end
            end
        end
        return res;
    endfunction

    // Split code and priority to output queue
    function automatic logic [PRIO_W-1:0] map_queue(input logic [1:0] code, input logic [PRIO_W-1:0] pr);
        logic [PRIO_W-1:0] q;
        case (split_mode_t'(code))
            SPLIT_TWO: q = {1'b0, pr[PRIO_W-1]};
            SPLIT_FOUR: q = pr;
            SPLIT_ONE: q = QUEUE_ZERO;
            default: q = QUEUE_ZERO;
        endcase
        return q;
    endfunction

    logic rst_meta;
    logic rst_n;
    logic [DATA_W-1:0] ctrl [NUM_PORTS];
    logic [DATA_W-1:0] next_ctrl [NUM_PORTS];
    logic split_hi [NUM_PORTS];
    logic next_split_hi [NUM_PORTS];
    logic [DATA_W-1:0] next_rdata;
    logic [PORT_W+1:0] dec;
    logic [PORT_W:0] c_sel;
    logic [PORT_W:0] e_sel;
    logic [DATA_W-1:0] c_ctrl;
    logic [DATA_W-1:0] e_ctrl;
    logic [1:0] e_code;
    logic next_class_valid;
    logic [PRIO_W-1:0] next_class_prio;
    logic next_egr_valid;
    logic [PRIO_W-1:0] next_egr_queue;
    logic next_insert;
    logic next_strip;
    logic [VID_W-1:0] next_vid;
    logic [NUM_PORTS-1:0] next_storm;

    // Reset release through two flops
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Register writes and read mux
    always_comb begin
        dec = decode(reg_addr_i);
        next_rdata = READ_ZERO;
        for (int p = 0; p < NUM_PORTS; p++) begin
            next_ctrl[p] = ctrl[p];
            next_split_hi[p] = split_hi[p];
            next_storm[p] = ctrl[p][STORM_BIT];
        end
        if (dec[PORT_W+1] && reg_wr_i) begin
            if (dec[PORT_W]) begin
                next_split_hi[dec[PORT_W-1:0]] = reg_wdata_i[SPLIT_HI_BIT];
            end else begin
                next_ctrl[dec[PORT_W-1:0]] = reg_wdata_i;
                next_storm[dec[PORT_W-1:0]] = reg_wdata_i[STORM_BIT];
            end
        end
        if (dec[PORT_W+1] && reg_rd_i) begin
            if (dec[PORT_W]) begin
                next_rdata[SPLIT_HI_BIT] = split_hi[dec[PORT_W-1:0]];
            end else begin
                next_rdata = ctrl[dec[PORT_W-1:0]];
            end
        end
    end

    // Register state, all zero after reset
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                ctrl[p] <= CTRL_RESET;
                split_hi[p] <= SPLIT_RESET;
            end
            reg_rdata_o <= READ_ZERO;
            storm_protect_o <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                ctrl[p] <= next_ctrl[p];
                split_hi[p] <= next_split_hi[p];
            end
            reg_rdata_o <= next_rdata;
            storm_protect_o <= next_storm;
        end
    end

    // Ingress priority classification
    always_comb begin
        c_sel = port_slot(class_port_i);
        c_ctrl = c_sel[PORT_W] ? ctrl[c_sel[PORT_W-1:0]] : CTRL_RESET;
        next_class_valid = class_req_i;
        next_class_prio = c_ctrl[DEF_PRIO_HI:DEF_PRIO_LO];
        if (c_ctrl[DSCP_EN_BIT] && dscp_hit_i && c_ctrl[DOT1P_EN_BIT] && dot1p_hit_i) begin
            next_class_prio = dscp_prio_i | dot1p_prio_i;
        end else if (c_ctrl[DSCP_EN_BIT] && dscp_hit_i) begin
            next_class_prio = dscp_prio_i;
        end else if (c_ctrl[DOT1P_EN_BIT] && dot1p_hit_i) begin
            next_class_prio = dot1p_prio_i;
        end
    end

    // Egress queue and tag decisions
    always_comb begin
        e_sel = port_slot(egr_port_i);
        e_ctrl = e_sel[PORT_W] ? ctrl[e_sel[PORT_W-1:0]] : CTRL_RESET;
        e_code = {e_sel[PORT_W] & split_hi[e_sel[PORT_W-1:0]], e_ctrl[SPLIT_LO_BIT]};
        next_egr_valid = egr_req_i;
        next_egr_queue = map_queue(e_code, egr_prio_i);
        next_insert = e_ctrl[INSERT_BIT] && !arrived_tagged_i;
        next_strip = e_ctrl[REMOVE_BIT] && arrived_tagged_i;
        next_vid = next_insert ? port_default_vlan_id_i : VID_ZERO;
    end

    // Answer flops, one cycle after the request
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            class_valid_o <= 1'b0;
            class_prio_o <= QUEUE_ZERO;
            egr_valid_o <= 1'b0;
            egr_queue_o <= QUEUE_ZERO;
            insert_tag_o <= 1'b0;
            strip_tag_o <= 1'b0;
            tag_vid_o <= VID_ZERO;
        end else begin
            class_valid_o <= next_class_valid;
            class_prio_o <= next_class_prio;
            egr_valid_o <= next_egr_valid;
            egr_queue_o <= next_egr_queue;
            insert_tag_o <= next_insert;
            strip_tag_o <= next_strip;
            tag_vid_o <= next_vid;
        end
    end

    // Checks on the fabric answers
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n);

    logic c_dscp;
    logic c_dot1p;
    assign c_dscp = c_ctrl[DSCP_EN_BIT] && dscp_hit_i;
    assign c_dot1p = c_ctrl[DOT1P_EN_BIT] && dot1p_hit_i;

    chk_dscp_only_prio: assert property (
        class_req_i && c_dscp && !c_dot1p |=> class_valid_o && class_prio_o == $past(dscp_prio_i))
        else $error("dscp priority not used");

    chk_dot1p_only_prio: assert property (
        class_req_i && c_dot1p && !c_dscp |=> class_valid_o && class_prio_o == $past(dot1p_prio_i))
        else $error("802.1p priority not used");

    chk_default_prio: assert property (
        class_req_i && !c_dscp && !c_dot1p && c_sel[PORT_W]
        |=> class_prio_o == $past(ctrl[c_sel[PORT_W-1:0]][DEF_PRIO_HI:DEF_PRIO_LO]))
        else $error("default priority not used");

    chk_or_combined: assert property (
        class_req_i && c_dscp && c_dot1p |=> class_prio_o == ($past(dscp_prio_i) | $past(dot1p_prio_i)))
        else $error("combined priority wrong");

    chk_insert_untagged: assert property (
        egr_req_i && e_ctrl[INSERT_BIT] && !arrived_tagged_i
        |=> insert_tag_o && tag_vid_o == $past(port_default_vlan_id_i))
        else $error("tag not inserted");

    chk_no_double_tag: assert property (
        egr_req_i && arrived_tagged_i |=> !insert_tag_o)
        else $error("second tag inserted");

    chk_strip_tagged: assert property (
        egr_req_i && arrived_tagged_i |=> strip_tag_o == $past(e_ctrl[REMOVE_BIT]))
        else $error("tag removal wrong");

    chk_untagged_kept: assert property (
        egr_req_i && !arrived_tagged_i |=> !strip_tag_o)
        else $error("untagged frame altered");

    chk_single_queue: assert property (
        egr_req_i && e_code == SPLIT_ONE |=> egr_queue_o == QUEUE_ZERO)
        else $error("single queue not honoured");

    chk_four_queue: assert property (
        egr_req_i && e_code == SPLIT_FOUR |=> egr_queue_o == $past(egr_prio_i))
        else $error("four queue split wrong");

    // Two queues: upper priority half goes to queue one
    chk_two_queue: assert property (
        egr_req_i && e_code == SPLIT_TWO |=> egr_queue_o == {1'b0, $past(egr_prio_i[PRIO_W-1])})
        else $error("two queue split wrong");

    // Reserved split code falls back to one queue
    chk_reserved_queue: assert property (
        egr_req_i && e_code == SPLIT_RSVD |=> egr_queue_o == QUEUE_ZERO)
        else $error("reserved split code not single queue");

    // Unmapped port numbers leave frames alone
    chk_invalid_port: assert property (
        egr_req_i && !e_sel[PORT_W] |=> egr_queue_o == QUEUE_ZERO && !insert_tag_o && !strip_tag_o)
        else $error("unmapped port changed frame");

    // Read data stand only after a read strobe
    chk_rdata_idle: assert property (
        !reg_rd_i |=> reg_rdata_o == READ_ZERO)
        else $error("read data without read");

    // Write then read of the same control register
    sequence ctrl_write_s;
        reg_wr_i && dec[PORT_W+1] && !dec[PORT_W];
    endsequence
    sequence same_read_s;
        reg_rd_i && $stable(reg_addr_i);
    endsequence

    chk_ctrl_readback: assert property (
        ctrl_write_s ##1 same_read_s |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("control readback wrong");

    chk_storm_follows: assert property (
        ctrl_write_s |=> storm_protect_o[$past(dec[PORT_W-1:0])] == $past(reg_wdata_i[STORM_BIT]))
        else $error("storm enable not updated");

    chk_reset_state: assert property (
        $rose(rst_n) |-> storm_protect_o == '0 && !insert_tag_o && !strip_tag_o)
        else $error("reset state not clean");

endmodule

/* src/port_prio_tag_pkg.sv */
/*
 Constants for the per-port priority and tag control bank.
 Assumes one byte-wide register per word; byte address is four times the index.
*/
package port_prio_tag_pkg;
    localparam int NUM_PORTS = 5;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int PORT_W = 3;
    localparam int PRIO_W = 2;
    localparam int VID_W = 12;
    localparam int IDX_W = 8;
    // Register indexes, first port and step between ports
    localparam logic [IDX_W-1:0] CTRL_IDX_FIRST = 8'h10;
    localparam logic [IDX_W-1:0] CTRL_IDX_STEP = 8'h10;
    localparam logic [IDX_W-1:0] SPLIT_IDX_FIRST = 8'hB1;
    localparam logic [IDX_W-1:0] SPLIT_IDX_STEP = 8'h10;
    localparam logic [1:0] LANE_ZERO = 2'h0;
    // Port numbering on the fabric side
    localparam logic [PORT_W-1:0] PORT_FIRST = 3'h1;
    localparam logic [PORT_W-1:0] PORT_LAST = 3'h5;
    // Control register fields
    localparam int STORM_BIT = 7;
    localparam int DSCP_EN_BIT = 6;
    localparam int DOT1P_EN_BIT = 5;
    localparam int DEF_PRIO_HI = 4;
    localparam int DEF_PRIO_LO = 3;
    localparam int INSERT_BIT = 2;
    localparam int REMOVE_BIT = 1;
    localparam int SPLIT_LO_BIT = 0;
    // Companion register field
    localparam int SPLIT_HI_BIT = 1;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic SPLIT_RESET = 1'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [PRIO_W-1:0] QUEUE_ZERO = 2'h0;
    localparam logic [VID_W-1:0] VID_ZERO = 12'h000;
    // Output queue split codes
    typedef enum logic [1:0] {
        SPLIT_ONE = 2'b00,
        SPLIT_TWO = 2'b01,
        SPLIT_FOUR = 2'b10,
        SPLIT_RSVD = 2'b11
    } split_mode_t;
endpackage
